// File: rtl/tis_cfg.svh
`ifndef TIS_CFG_SVH
`define TIS_CFG_SVH

// ==========================================================================
// Stack checking
`define TIS_STACK_FLOOR 16'h0800

// ==========================================================================
// Trap slots, counted from the lowest trap level
`define TIS_TRAP_BASE 4'h8
`define TIS_MATH_IDX 3
`define TIS_ADDR_IDX 4
`define TIS_STACK_IDX 5
`define TIS_OSC_IDX 6
`define TIS_HARD_MASK 8'hF0
`define TIS_SOFT_MASK 8'h0F

// ==========================================================================
// Vector index of the first ordinary interrupt
`define TIS_INT_VEC_OFS 8

// ==========================================================================
// Bit positions in status words
`define TIS_CONFLICT_BIT 15
`define TIS_TRAP_LVL_BIT 3

`endif

// File: rtl/tis_pkg.sv
package tis_pkg;
  typedef logic [3:0] level_t;
  typedef logic [2:0] prio_t;
  typedef logic [7:0] trap_vec_t;
endpackage

// File: rtl/trap_and_interrupt_sequencer.sv
`timescale 1ns/10ps
`include "tis_cfg.svh"

module trap_and_interrupt_sequencer
  import tis_pkg::*;
#(
  parameter int NIRQ = 8,
  parameter int NEXT = 5,
  parameter int ADDR_W = 24,
  parameter int WREG_W = 16,
  parameter logic [23:0] DEF_BASE = 24'h00_0004,
  parameter logic [23:0] ALT_BASE = 24'h00_0084
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Stack monitor
  input wire logic sp_load_i,
  input wire logic [15:0] sp_value_i,
  input wire logic [15:0] stack_limit_register_i,
  // Trap sources
  input wire logic osc_fail_i,
  input wire logic addr_err_i,
  input wire logic math_err_i,
  // Interrupt sources and control
  input wire logic [NIRQ-1:0] irq_event_i,
  input wire logic [NEXT-1:0] external_request_inputs_i,
  input wire logic [NEXT-1:0] external_edge_polarity_i,
  input wire logic [NIRQ+NEXT-1:0] interrupt_enable_registers_i,
  input wire logic [3*(NIRQ+NEXT)-1:0] irq_priority_i,
  input wire logic [NIRQ+NEXT-1:0] flag_clear_i,
  input wire logic alternate_vector_select_i,
  input wire logic trap_conflict_reset_flag_clear_i,
  // Processor core
  input wire logic [ADDR_W-1:0] pc_i,
  input wire logic [4:0] status_low_i,
  input wire logic core_ack_i,
  input wire logic return_from_interrupt_i,
  input wire logic [7:0] pop_srl_i,
  input wire logic pop_trap_level_i,
  input wire logic sr_write_i,
  input wire logic [2:0] sr_ipl_i,
  input wire logic sleep_i,
  // Shadow context
  input wire logic shadow_push_i,
  input wire logic shadow_pop_i,
  input wire logic [4:0] sr_flags_i,
  input wire logic [4*WREG_W-1:0] w_regs_i,
  // Request to core
  output logic irq_req_o,
  output logic [ADDR_W-1:0] vector_o,
  output logic halt_o,
  output logic wake_o,
  // Stack frame
  output logic push_o,
  output logic [ADDR_W-1:0] push_pc_o,
  output logic [7:0] push_srl_o,
  // Status
  output logic [2:0] cpu_priority_level_o,
  output logic [15:0] core_control_register_o,
  output logic [15:0] reset_control_register_o,
  output logic device_reset_o,
  output logic [7:0] trap_pending_o,
  output logic [NIRQ+NEXT-1:0] interrupt_flag_registers_o,
  // Shadow restore
  output logic shadow_restore_o,
  output logic [4:0] shadow_flags_o,
  output logic [4*WREG_W-1:0] shadow_w_o
);

  localparam int NF = NIRQ + NEXT;

  // ========================================================================
  // Helpers
  function automatic logic [2:0] top_trap(input trap_vec_t p);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (p[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  // ========================================================================
  // State
  trap_vec_t trap_pend_q, trap_pend_d, trap_busy_q, trap_busy_d;
  logic [NF-1:0] flag_q;
  logic [NEXT-1:0] ext_prev_q;
  logic [2:0] ipl_q, ipl_d;
  logic trap_level_bit_q, trap_level_bit_d;
  logic req_q, conflict_q, trap_conflict_reset_flag_q, push_q, restore_q;
  logic [ADDR_W-1:0] vec_q, push_pc_q;
  logic [7:0] push_srl_q;
  level_t pres_lvl_q;
  logic pres_trap_q;
  logic [4:0] sh_flags_q;
  logic [4*WREG_W-1:0] sh_w_q;

  // ========================================================================
  // Trap detection
  wire clr = rst_i | conflict_q;
  wire sp_over = sp_value_i > stack_limit_register_i;
  wire sp_under = sp_value_i < `TIS_STACK_FLOOR;
  wire stack_err = sp_load_i & (sp_over | sp_under);
  trap_vec_t trap_evt;
  wire trap_vec_t hard_mask = `TIS_HARD_MASK;
  wire trap_vec_t held = trap_pend_q | trap_busy_q;
  logic conflict;

  always_comb begin
    trap_evt = '0;
    trap_evt[`TIS_MATH_IDX] = math_err_i;
    trap_evt[`TIS_ADDR_IDX] = addr_err_i;
    trap_evt[`TIS_STACK_IDX] = stack_err;
    trap_evt[`TIS_OSC_IDX] = osc_fail_i;
  end

  // A new hard trap below any held trap cannot be nested safely.
  always_comb begin
    conflict = 1'b0;
    for (int j = 0; j < 8; j++) begin
      if (trap_evt[j] && hard_mask[j] &&
          |(held & (8'hFF << (j + 1)))) begin
        conflict = 1'b1;
      end
    end
  end

  // ========================================================================
  // Interrupt flags and selection
  wire [NEXT-1:0] ext_rise = external_request_inputs_i & ~ext_prev_q;
  wire [NEXT-1:0] ext_fall = ~external_request_inputs_i & ext_prev_q;
  wire [NEXT-1:0] ext_edge =
    (external_edge_polarity_i & ext_fall) |
    (~external_edge_polarity_i & ext_rise);
  wire [NF-1:0] flag_src = {ext_edge, irq_event_i};
  wire [NF-1:0] pend_int = flag_q & interrupt_enable_registers_i;
  prio_t i_prio;
  logic [7:0] i_idx;
  logic i_any;

  // Lowest index wins among equal priorities.
  always_comb begin
    i_prio = 3'h0;
    i_idx = 8'h00;
    i_any = 1'b0;
    for (int i = 0; i < NF; i++) begin
      if (pend_int[i] && (!i_any || irq_priority_i[3*i +: 3] > i_prio)) begin
        i_prio = irq_priority_i[3*i +: 3];
        i_idx = 8'(i);
        i_any = 1'b1;
      end
    end
  end

  wire level_t cur_lvl = {trap_level_bit_q, ipl_q};
  wire [2:0] t_idx = top_trap(trap_pend_q);
  wire level_t t_lvl = `TIS_TRAP_BASE | {1'b0, t_idx};
  wire take_trap = (|trap_pend_q) && (t_lvl > cur_lvl);
  // Interrupt levels never exceed seven, so level seven blocks them all.
  wire take_int = i_any && !trap_level_bit_q && (i_prio > ipl_q);
  wire want = take_trap | take_int;
  wire [7:0] vidx = take_trap ? {5'h00, t_idx} :
                    8'(i_idx + `TIS_INT_VEC_OFS);
  wire [23:0] base = alternate_vector_select_i ? ALT_BASE : DEF_BASE;
  wire [ADDR_W-1:0] vec_d = ADDR_W'(base + {15'h0000, vidx, 1'b0});
  wire level_t pres_lvl_d = take_trap ? t_lvl : {1'b0, i_prio};
  wire accept = req_q & core_ack_i;
  wire trap_vec_t acc_mask = 8'(8'h01 << pres_lvl_q[2:0]);

  // ========================================================================
  // Priority and trap bookkeeping
  always_comb begin
    ipl_d = ipl_q;
    trap_level_bit_d = trap_level_bit_q;
    trap_busy_d = trap_busy_q;
    if (accept) begin
      ipl_d = pres_lvl_q[2:0];
      trap_level_bit_d = pres_trap_q;
      if (pres_trap_q) begin
        trap_busy_d = trap_busy_q | acc_mask;
      end
    end else if (return_from_interrupt_i) begin
      ipl_d = pop_srl_i[7:5];
      trap_level_bit_d = pop_trap_level_i;
      if (trap_level_bit_q) begin
        trap_busy_d = trap_busy_q & ~trap_vec_t'(8'h01 << ipl_q);
      end
    end else if (sr_write_i) begin
      ipl_d = sr_ipl_i;
    end
  end

  // New trap events win over the clear made by acceptance.
  assign trap_pend_d = (trap_pend_q & ~((accept && pres_trap_q) ?
                        acc_mask : 8'h00)) | trap_evt;

  always_ff @(posedge clk_i) begin
    if (clr) begin
      trap_pend_q <= '0;
      trap_busy_q <= '0;
      flag_q <= '0;
      ext_prev_q <= '0;
      ipl_q <= 3'h0;
      trap_level_bit_q <= 1'b0;
      req_q <= 1'b0;
      vec_q <= '0;
      pres_lvl_q <= 4'h0;
      pres_trap_q <= 1'b0;
    end else begin
      trap_pend_q <= trap_pend_d;
      trap_busy_q <= trap_busy_d;
      flag_q <= (flag_q & ~flag_clear_i) | flag_src;
      ext_prev_q <= external_request_inputs_i;
      ipl_q <= ipl_d;
      trap_level_bit_q <= trap_level_bit_d;
      req_q <= want & ~accept;
      vec_q <= vec_d;
      pres_lvl_q <= pres_lvl_d;
      pres_trap_q <= take_trap;
    end
  end

  // ========================================================================
  // Conflict reset and its flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conflict_q <= 1'b0;
      trap_conflict_reset_flag_q <= 1'b0;
    end else begin
      conflict_q <= conflict & ~conflict_q;
      trap_conflict_reset_flag_q <= conflict | (trap_conflict_reset_flag_q & ~trap_conflict_reset_flag_clear_i);
    end
  end

  // ========================================================================
  // Stack frame and shadow context
  always_ff @(posedge clk_i) begin
    if (clr) begin
      push_q <= 1'b0;
      push_pc_q <= '0;
      push_srl_q <= 8'h00;
      restore_q <= 1'b0;
      sh_flags_q <= 5'h00;
      sh_w_q <= '0;
    end else begin
      push_q <= accept;
      restore_q <= shadow_pop_i;
      if (accept) begin
        push_pc_q <= pc_i;
        push_srl_q <= {ipl_q, status_low_i};
      end
      if (shadow_push_i) begin
        sh_flags_q <= sr_flags_i;
        sh_w_q <= w_regs_i;
      end
    end
  end

  // ========================================================================
  // Outputs
  assign irq_req_o = req_q;
  assign vector_o = vec_q;
  assign halt_o = |(trap_pend_q & hard_mask);
  assign wake_o = sleep_i & want;
  assign push_o = push_q;
  assign push_pc_o = push_pc_q;
  assign push_srl_o = push_srl_q;
  assign cpu_priority_level_o = ipl_q;
  assign core_control_register_o = 16'(trap_level_bit_q) << `TIS_TRAP_LVL_BIT;
  assign reset_control_register_o = 16'(trap_conflict_reset_flag_q) << `TIS_CONFLICT_BIT;
  assign device_reset_o = conflict_q;
  assign trap_pending_o = trap_pend_q;
  assign interrupt_flag_registers_o = flag_q;
  assign shadow_restore_o = restore_q;
  assign shadow_flags_o = sh_flags_q;
  assign shadow_w_o = sh_w_q;

  // ========================================================================
  // Checks
  a_stack_over: assert property (
    @(posedge clk_i) disable iff (rst_i)
    sp_load_i && sp_over && !conflict_q |=> trap_pend_q[`TIS_STACK_IDX])
    else $error("stack overflow not trapped");
  a_stack_under: assert property (
    @(posedge clk_i) disable iff (rst_i)
    sp_load_i && sp_under && !conflict_q |=> trap_pend_q[`TIS_STACK_IDX])
    else $error("stack underflow not trapped");
  a_osc_fail: assert property (
    @(posedge clk_i) disable iff (rst_i)
    osc_fail_i && !conflict_q |=> trap_pend_q[`TIS_OSC_IDX])
    else $error("oscillator fail not trapped");
  a_conflict_reset: assert property (
    @(posedge clk_i) disable iff (rst_i)
    conflict && !conflict_q |=> device_reset_o && trap_conflict_reset_flag_q ##1
    trap_pend_q == 8'h00)
    else $error("conflict did not reset");
  a_halt_hard: assert property (
    @(posedge clk_i) disable iff (rst_i)
    addr_err_i && !conflict_q |=> halt_o)
    else $error("hard trap did not halt");
  a_int_blocked: assert property (
    @(posedge clk_i) disable iff (rst_i)
    req_q && !pres_trap_q |-> $past(!trap_level_bit_q) && pres_lvl_q > {1'b0,
    $past(ipl_q)})
    else $error("interrupt presented at or below level");
  a_accept_push: assert property (
    @(posedge clk_i) disable iff (clr)
    accept |=> push_o && push_srl_o[7:5] == $past(ipl_q) &&
    cpu_priority_level_o == $past(pres_lvl_q[2:0]))
    else $error("accept did not stack and load level");
  a_trap_bit: assert property (
    @(posedge clk_i) disable iff (clr)
    accept |=> core_control_register_o[`TIS_TRAP_LVL_BIT] ==
    $past(pres_trap_q))
    else $error("trap level bit wrong after accept");
  a_flag_sample: assert property (
    @(posedge clk_i) disable iff (clr)
    irq_event_i[0] |=> interrupt_flag_registers_o[0])
    else $error("event not sampled into flag");
  a_trap_first: assert property (
    @(posedge clk_i) disable iff (rst_i)
    take_trap && !clr |=> pres_trap_q && pres_lvl_q[3])
    else $error("interrupt chosen over trap");

endmodule

// File: tb/core_model.sv
`timescale 1ns/10ps
// ==========================================================================
// Core stand-in
// Acknowledges a presented request after a set number of cycles.
module core_model (
  // Clock and control from the bench
  input wire logic clk_i,
  input wire logic auto_ack_i,
  input wire logic [3:0] ack_delay_i,
  // Request from the sequencer
  input wire logic irq_req_i,
  // Acknowledge to the sequencer
  output logic core_ack_o
);
  logic [3:0] wait_q;

  initial begin
    core_ack_o = 1'b0;
    wait_q = 4'h0;
  end

  // The acknowledge is a one-cycle pulse so one request is never taken twice.
  always @(posedge clk_i) begin
    wait_q <= irq_req_i ? wait_q + 4'h1 : 4'h0;
    core_ack_o <= auto_ack_i && irq_req_i && !core_ack_o &&
                  (wait_q >= ack_delay_i);
  end
endmodule

// File: tb/tb_trap_and_interrupt_sequencer.sv
`timescale 1ns/10ps
module tb_trap_and_interrupt_sequencer;
  import tis_pkg::*;
  localparam logic [23:0] DB = 24'h00_0004;
  localparam logic [23:0] AB = 24'h00_0084;
  logic clk_i, rst_i, sp_load_i, osc_i, addr_i, math_i, alt_i, trclr_i;
  logic ack_i, reti_i, poptl_i, srw_i, sleep_i, spush_i, spop_i, auto_ack;
  logic [15:0] sp_i, lim_i, ccr_o, rcr_o;
  logic [7:0] ev_i, popsrl_i, srl_o, tp_o;
  logic [4:0] ext_i, pol_i, stl_i, srf_i, shf_o;
  logic [12:0] en_i, clr_i, fl_o;
  logic [38:0] prio_i;
  logic [2:0] ipl_i, lvl_o;
  logic [63:0] w_i, shw_o;
  logic [23:0] vec_o, pc_o, pc_i;
  logic req_o, halt_o, wake_o, push_o, drst_o, shr_o;
  logic [3:0] ack_delay;
  int bad_count, samples_checked;

  trap_and_interrupt_sequencer #(.DEF_BASE(DB), .ALT_BASE(AB))
    u_trap_and_interrupt_sequencer (
    .clk_i(clk_i), .rst_i(rst_i), .sp_load_i(sp_load_i), .sp_value_i(sp_i),
    .stack_limit_register_i(lim_i), .osc_fail_i(osc_i), .addr_err_i(addr_i),
    .math_err_i(math_i), .irq_event_i(ev_i),
    .external_request_inputs_i(ext_i), .external_edge_polarity_i(pol_i),
    .interrupt_enable_registers_i(en_i), .irq_priority_i(prio_i),
    .flag_clear_i(clr_i), .alternate_vector_select_i(alt_i),
    .trap_conflict_reset_flag_clear_i(trclr_i), .pc_i(pc_i), .status_low_i(stl_i),
    .core_ack_i(ack_i), .return_from_interrupt_i(reti_i),
    .pop_srl_i(popsrl_i), .pop_trap_level_i(poptl_i), .sr_write_i(srw_i),
    .sr_ipl_i(ipl_i), .sleep_i(sleep_i), .shadow_push_i(spush_i),
    .shadow_pop_i(spop_i), .sr_flags_i(srf_i), .w_regs_i(w_i),
    .irq_req_o(req_o), .vector_o(vec_o), .halt_o(halt_o), .wake_o(wake_o),
    .push_o(push_o), .push_pc_o(pc_o), .push_srl_o(srl_o),
    .cpu_priority_level_o(lvl_o), .core_control_register_o(ccr_o),
    .reset_control_register_o(rcr_o), .device_reset_o(drst_o),
    .trap_pending_o(tp_o), .interrupt_flag_registers_o(fl_o),
    .shadow_restore_o(shr_o), .shadow_flags_o(shf_o), .shadow_w_o(shw_o));

  core_model u_core_model (.clk_i(clk_i), .auto_ack_i(auto_ack),
    .ack_delay_i(ack_delay), .irq_req_i(req_o), .core_ack_o(ack_i));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // ==========================================================================
  // Bench tasks
  task finish_test();
    $display("compares %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task chk(input string n, input logic [63:0] e, input logic [63:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  function automatic logic sig(input int s);
    case (s)
      0: return req_o;
      1: return push_o;
      2: return drst_o;
      default: return shr_o;
    endcase
  endfunction

  task wait_for(input int s);
    int k;
    k = 0;
    while (sig(s) !== 1'b1 && k < 30) begin
      cyc(1);
      k++;
    end
    if (sig(s) !== 1'b1) begin
      bad_count++;
      $display("CHECK FAILED wait %0d expected 1 seen 0", s);
      finish_test();
    end
  endtask

  task do_reset();
    rst_i = 1'b1;
    cyc(3);
    rst_i = 1'b0;
  endtask

  task set_ipl(input logic [2:0] v);
    ipl_i = v;
    srw_i = 1'b1;
    cyc(1);
    srw_i = 1'b0;
    cyc(2);
  endtask

  task ret(input logic [7:0] b, input logic t);
    popsrl_i = b;
    poptl_i = t;
    reti_i = 1'b1;
    cyc(1);
    reti_i = 1'b0;
    cyc(1);
  endtask

  // ==========================================================================
  // Scenarios
  initial begin
    {sp_load_i, osc_i, addr_i, math_i, alt_i, trclr_i, reti_i} = '0;
    {poptl_i, srw_i, sleep_i, spush_i, spop_i, auto_ack, ack_delay} = '0;
    {sp_i, lim_i, ev_i, popsrl_i, ext_i, pol_i, stl_i, srf_i} = '0;
    {en_i, clr_i, prio_i, ipl_i, w_i} = '0;
    pc_i = 24'h00_1234;
    bad_count = 0;
    samples_checked = 0;
    do_reset();
    chk("reset", 0, {req_o, halt_o, push_o, tp_o, rcr_o, ccr_o, lvl_o});
    auto_ack = 1'b1;
    addr_i = 1'b1;
    cyc(1);
    addr_i = 1'b0;
    chk("trap_pending", 8'h10, tp_o);
    chk("halt", 1, halt_o);
    wait_for(0);
    chk("vector", DB + 24'h00_0008, vec_o);
    wait_for(1);
    chk("push_pc", 24'h00_1234, pc_o);
    chk("core_control", 16'h0008, ccr_o);
    chk("halt", 0, halt_o);
    ret(8'h00, 1'b0);
    chk("core_control", 16'h0000, ccr_o);
    math_i = 1'b1;
    cyc(1);
    math_i = 1'b0;
    chk("trap_pending", 8'h08, tp_o);
    chk("halt", 0, halt_o);
    do_reset();
    auto_ack = 1'b0;
    en_i = 13'h0001;
    prio_i[2:0] = 3'h7;
    {ev_i, osc_i, addr_i} = {8'h01, 1'b1, 1'b1};
    cyc(1);
    {ev_i, osc_i, addr_i} = '0;
    chk("trap_pending", 8'h50, tp_o);
    wait_for(0);
    chk("vector", DB + 24'h00_000C, vec_o);
    auto_ack = 1'b1;
    wait_for(1);
    auto_ack = 1'b0;
    chk("trap_pending", 8'h10, tp_o);
    chk("halt", 1, halt_o);
    do_reset();
    lim_i = 16'h1000;
    {sp_load_i, sp_i} = {1'b1, 16'h0800};
    cyc(1);
    sp_i = 16'h1000;
    cyc(1);
    sp_load_i = 1'b0;
    chk("trap_pending", 8'h00, tp_o);
    {sp_load_i, sp_i} = {1'b1, 16'h07FE};
    cyc(1);
    sp_load_i = 1'b0;
    chk("trap_pending", 8'h20, tp_o);
    addr_i = 1'b1;
    cyc(1);
    addr_i = 1'b0;
    wait_for(2);
    chk("reset_control", 16'h8000, rcr_o);
    cyc(2);
    chk("trap_pending", 8'h00, tp_o);
    trclr_i = 1'b1;
    cyc(1);
    trclr_i = 1'b0;
    chk("reset_control", 16'h0000, rcr_o);
    {sp_load_i, sp_i} = {1'b1, 16'h1002};
    cyc(1);
    sp_load_i = 1'b0;
    chk("trap_pending", 8'h20, tp_o);
    do_reset();
    pc_i = 24'h00_5678;
    {alt_i, en_i, stl_i, ev_i} = {1'b1, 13'h0004, 5'h0A, 8'h04};
    prio_i[8:6] = 3'h5;
    cyc(1);
    ev_i = 8'h00;
    chk("flags", 13'h0004, fl_o);
    wait_for(0);
    chk("vector", AB + 24'h00_0014, vec_o);
    auto_ack = 1'b1;
    wait_for(1);
    auto_ack = 1'b0;
    chk("push_pc", 24'h00_5678, pc_o);
    chk("push_srl", 8'h0A, srl_o);
    chk("level", 3'h5, lvl_o);
    chk("core_control", 16'h0000, ccr_o);
    clr_i = 13'h0004;
    cyc(1);
    clr_i = 13'h0000;
    ret(8'h0A, 1'b0);
    chk("level", 3'h0, lvl_o);
    {ev_i, en_i, sleep_i} = {8'h04, 13'h0000, 1'b1};
    cyc(1);
    ev_i = 8'h00;
    cyc(2);
    chk("request", 0, {req_o, wake_o});
    en_i = 13'h0004;
    cyc(2);
    chk("request", 2'h3, {req_o, wake_o});
    sleep_i = 1'b0;
    set_ipl(3'h5);
    chk("request", 0, req_o);
    set_ipl(3'h4);
    chk("request", 1, req_o);
    set_ipl(3'h7);
    chk("request", 0, req_o);
    math_i = 1'b1;
    cyc(1);
    math_i = 1'b0;
    cyc(2);
    chk("vector", {1'b1, AB + 24'h00_0006},
        {req_o, vec_o});
    do_reset();
    {pol_i, ext_i} = {5'h02, 5'h02};
    cyc(2);
    chk("flags", 13'h0000, fl_o);
    ext_i = 5'h01;
    cyc(2);
    chk("flags", 13'h0300, fl_o);
    {srf_i, w_i, spush_i} = {5'h15, 64'h1111_2222_3333_4444, 1'b1};
    cyc(1);
    {srf_i, w_i, spush_i, spop_i} = {70'h0, 1'b1};
    cyc(1);
    spop_i = 1'b0;
    wait_for(3);
    chk("shadow_flags", 5'h15, shf_o);
    chk("shadow_w", 64'h1111_2222_3333_4444, shw_o);
    finish_test();
  end
endmodule
